// file: verilog/srr_pkg.sv
// package: constants and carrier types for the release/report command handler
package srr_pkg;
	localparam logic [7:0]  OP_RECV_DIAG    = 8'h1c;
	localparam logic [7:0]  OP_RELEASE6     = 8'h17;
	localparam logic [7:0]  OP_RELEASE10    = 8'h57;
	localparam logic [7:0]  OP_MAINT_IN     = 8'ha3;
	localparam logic [7:0]  OP_REPORT_LUNS  = 8'ha0;
	localparam logic [4:0]  SA_REPORT_ID    = 5'h05;
	localparam logic [7:0]  PAGE_LED        = 8'ha0;
	localparam logic [15:0] LED_PAGE_LEN    = 16'h0002;
	localparam logic [15:0] LED_PAGE_BYTES  = 16'h0006;
	localparam logic [31:0] LUN_LIST_LEN    = 32'h0000_0008;
	localparam logic [31:0] LUN_MIN_ALLOC   = 32'h0000_0010;
	localparam logic [31:0] LUN_LIST_BYTES  = 32'h0000_0010;
	localparam int          ID_MAX_BYTES    = 16;
	localparam int          ID_AW           = 4;
	localparam logic [31:0] ID_RESET_LEN    = 32'h0000_0000;
	localparam logic [3:0]  SK_NOT_READY    = 4'h2;
	localparam logic [3:0]  SK_ILLEGAL_REQ  = 4'h5;
	localparam logic [7:0]  ASC_INVALID_CDB = 8'h24;
	localparam logic [7:0]  ASC_NOT_READY   = 8'h04;
	localparam logic [7:0]  ASCQ_NONE       = 8'h00;
	localparam logic [7:0]  ST_GOOD         = 8'h00;
	localparam logic [7:0]  ST_CHECK        = 8'h02;
	// bit positions inside cdb byte 1
	localparam int          B1_THIRD_PARTY  = 4;
	localparam int          B1_EXTENT       = 0;
	localparam int          B1_PCV          = 0;

	typedef enum logic [2:0] {
		SRR_IDLE = 3'b000,
		SRR_XFER = 3'b001,
		SRR_DONE = 3'b010
	} srr_state_t;

	typedef enum logic [1:0] {
		SRR_SRC_LED = 2'b00,
		SRR_SRC_ID  = 2'b01,
		SRR_SRC_LUN = 2'b10
	} srr_src_t;

	typedef struct packed {
		logic [3:0] key;
		logic [7:0] asc;
		logic [7:0] ascq;
	} srr_sense_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} srr_byte_t;

	typedef struct packed {
		logic [7:0] status;
		srr_sense_t sense;
	} srr_result_t;
endpackage

// file: verilog/srr_id_mem.sv
// memory for the persistent device identifier bytes
`timescale 1ns/1ps
module srr_id_mem (
	input  wire logic                    clk_i,
	input  wire logic                    we_i,
	input  wire logic [srr_pkg::ID_AW-1:0] waddr_i,
	input  wire logic [7:0]              wdata_i,
	input  wire logic [srr_pkg::ID_AW-1:0] raddr_i,
	output logic      [7:0]              rdata_o
);
	import srr_pkg::*;
	logic [7:0] mem [ID_MAX_BYTES];

	// no reset: content is loaded from nonvolatile storage, never cleared
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// file: verilog/srr_cmd.sv
// command handler: led page, release 6/10, report device identifier, report luns
`timescale 1ns/1ps
// Functional notes
// - led page answers with code a0h, led control bit at byte 5 bit 0
// - opcode 17h is six-byte release; byte 1 flags expected zero
// - third-party flag set on release gives illegal request, invalid field
// - reservation and third-party ids ignored; extent flag must be zero
// - release without reservation completes good, state untouched
// - maintenance-in service action 05h returns the identifier data
// - nonzero lun in bytes 4-5 gives illegal request, invalid field
// - short allocation truncates identifier data without error
// - 4-byte identifier length first, not adjusted on truncation
// - identifier length starts zero, changes only on successful set
// - identifier lives in nonvolatile storage across resets; here only the bytes do, SYS_RST_I clears the length to zero
// - same identifier returned to every initiator and port
// - storage not ready gives immediate not-ready check condition
// - report luns a0h accepted whatever reservation is held
// - report luns allocation below 16 gives invalid field
// - report luns returns as many entries as fit, no error
// - lun list: length 8, four reserved, lun zero entry bytes 8-15
// - data stops at available bytes or allocation; zero allocation fine except for report luns
module srr_cmd (
	input  wire logic                MCLK_I,
	input  wire logic                SYS_RST_I,
	input  wire logic                CMD_VALID_I,
	input  wire logic [12*8-1:0]     CDB_I,
	input  wire logic                LED_CTRL_I,
	input  wire logic                NV_READY_I,
	input  wire logic                ID_WR_I,
	input  wire logic [srr_pkg::ID_AW-1:0] ID_WADDR_I,
	input  wire logic [7:0]          ID_WDATA_I,
	input  wire logic                ID_LEN_WR_I,
	input  wire logic [31:0]         ID_LEN_I,
	input  wire logic                DATA_READY_I,
	output srr_pkg::srr_byte_t       DATA_O,
	output logic                     BUSY_O,
	output logic                     DONE_O,
	output srr_pkg::srr_result_t     RESULT_O,
	output srr_pkg::srr_sense_t      SENSE_O,
	output logic                     RELEASE_O
);
	import srr_pkg::*;

	typedef struct packed {
		srr_state_t  state;
		srr_src_t    src;
		logic [31:0] idx;
		logic [31:0] limit;
		logic [31:0] id_len;
		logic        led_bit;
		srr_byte_t   dout;
		logic        busy;
		logic        done;
		srr_result_t result;
		srr_sense_t  sense;
		logic        release_p;
	} srr_regs_t;

	srr_regs_t r, nxt;
	logic [7:0]  cdb [12];
	logic [7:0]  id_rdata;
	logic [ID_AW-1:0] id_raddr;
	logic [31:0] alloc32;
	logic [15:0] alloc16;
	logic [31:0] avail;
	logic [7:0]  byte_val;
	logic [31:0] id_off;

	always_comb begin
		for (int i = 0; i < 12; i++) begin
			cdb[i] = CDB_I[(11-i)*8 +: 8];
		end
	end

	assign alloc32 = {cdb[6], cdb[7], cdb[8], cdb[9]};
	assign alloc16 = {cdb[3], cdb[4]};
	// identifier memory read one byte ahead of the output stage
	assign id_off   = nxt.idx - 32'h4;
	assign id_raddr = id_off[ID_AW-1:0];

	// one copy for all initiators and ports
	srr_id_mem u_id_mem (
		.clk_i   (MCLK_I),
		.we_i    (ID_WR_I),
		.waddr_i (ID_WADDR_I),
		.wdata_i (ID_WDATA_I),
		.raddr_i (id_raddr),
		.rdata_o (id_rdata)
	);

	always_comb begin
		avail = 32'h0;
		case (r.src)
			SRR_SRC_LED: avail = {16'h0, LED_PAGE_BYTES};
			SRR_SRC_ID:  avail = r.id_len + 32'h4;
			SRR_SRC_LUN: avail = LUN_LIST_BYTES;
			default:     avail = 32'h0;
		endcase
	end

	always_comb begin
		byte_val = 8'h00;
		case (r.src)
			SRR_SRC_LED: begin
				case (r.idx[2:0])
					3'h0:    byte_val = PAGE_LED;
					3'h2:    byte_val = LED_PAGE_LEN[15:8];
					3'h3:    byte_val = LED_PAGE_LEN[7:0];
					3'h5:    byte_val = {7'h00, r.led_bit};
					default: byte_val = 8'h00;
				endcase
			end
			SRR_SRC_ID: begin
				// length field as stored, never trimmed
				if (r.idx < 32'h4) begin
					byte_val = r.id_len[(3 - r.idx[1:0])*8 +: 8];
				end else begin
					byte_val = id_rdata;
				end
			end
			SRR_SRC_LUN: begin
				// bytes 4..15 are reserved and lun zero
				if (r.idx < 32'h4) begin
					byte_val = LUN_LIST_LEN[(3 - r.idx[1:0])*8 +: 8];
				end else begin
					byte_val = 8'h00;
				end
			end
			default: byte_val = 8'h00;
		endcase
	end

	always_comb begin
		nxt = r;
		nxt.done = 1'b0;
		nxt.release_p = 1'b0;
		// length register follows successful set writes; SYS_RST_I clears it to ID_RESET_LEN
		if (ID_LEN_WR_I) begin
			nxt.id_len = ID_LEN_I;
		end
		case (r.state)
			SRR_IDLE: begin
				nxt.dout = '0;
				if (CMD_VALID_I) begin
					nxt.busy = 1'b1;
					nxt.idx = 32'h0;
					nxt.result.status = ST_GOOD;
					nxt.result.sense = '0;
					nxt.state = SRR_DONE;
					case (cdb[0])
						OP_RECV_DIAG: begin
							nxt.src = SRR_SRC_LED;
							nxt.led_bit = LED_CTRL_I;
							nxt.limit = {16'h0, alloc16};
							nxt.state = SRR_XFER;
						end
						OP_RELEASE6, OP_RELEASE10: begin
							// ids in bytes 2/3 ignored
							if (cdb[1][B1_THIRD_PARTY] || cdb[1][B1_EXTENT]) begin
								nxt.result = {ST_CHECK, SK_ILLEGAL_REQ, ASC_INVALID_CDB, ASCQ_NONE};
							end else begin
								// no reservation held here: good, state untouched
								nxt.release_p = 1'b1;
							end
						end
						OP_MAINT_IN: begin
							if (cdb[1][4:0] != SA_REPORT_ID) begin
								nxt.result = {ST_CHECK, SK_ILLEGAL_REQ, ASC_INVALID_CDB, ASCQ_NONE};
							end else if ({cdb[4], cdb[5]} != 16'h0) begin
								nxt.result = {ST_CHECK, SK_ILLEGAL_REQ, ASC_INVALID_CDB, ASCQ_NONE};
							end else if (!NV_READY_I) begin
								nxt.result = {ST_CHECK, SK_NOT_READY, ASC_NOT_READY, ASCQ_NONE};
							end else begin
								nxt.src = SRR_SRC_ID;
								nxt.limit = alloc32;
								nxt.state = SRR_XFER;
							end
						end
						OP_REPORT_LUNS: begin
							if (alloc32 < LUN_MIN_ALLOC) begin
								nxt.result = {ST_CHECK, SK_ILLEGAL_REQ, ASC_INVALID_CDB, ASCQ_NONE};
							end else begin
								nxt.src = SRR_SRC_LUN;
								nxt.limit = alloc32;
								nxt.state = SRR_XFER;
							end
						end
						default: begin
							nxt.result = {ST_CHECK, SK_ILLEGAL_REQ, ASC_INVALID_CDB, ASCQ_NONE};
						end
					endcase
				end
			end
			SRR_XFER: begin
				if (r.dout.valid && !DATA_READY_I) begin
					nxt.dout = r.dout;
				end else if (r.idx >= avail || r.idx >= r.limit) begin
					nxt.dout = '0;
					nxt.state = SRR_DONE;
				end else begin
					nxt.dout.valid = 1'b1;
					nxt.dout.data = byte_val;
					nxt.dout.last = (r.idx + 32'h1 >= avail) || (r.idx + 32'h1 >= r.limit);
					nxt.idx = r.idx + 32'h1;
				end
			end
			SRR_DONE: begin
				nxt.busy = 1'b0;
				nxt.done = 1'b1;
				nxt.dout = '0;
				if (r.result.status == ST_CHECK) begin
					nxt.sense = r.result.sense;
				end
				nxt.state = SRR_IDLE;
			end
			default: nxt.state = SRR_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			r <= '{state: SRR_IDLE, src: SRR_SRC_LED, id_len: ID_RESET_LEN, default: '0};
		end else begin
			r <= nxt;
		end
	end

	assign DATA_O    = r.dout;
	assign BUSY_O    = r.busy;
	assign DONE_O    = r.done;
	assign RESULT_O  = r.result;
	assign SENSE_O   = r.sense;
	assign RELEASE_O = r.release_p;
endmodule

// file: tb/srr_cmd_assertions.sv
// checker: answer timing and status assertions for the command handler
`timescale 1ns/1ps
module srr_cmd_assertions import srr_pkg::*; (
	input wire logic  MCLK_I,
	input wire logic  SYS_RST_I,
	input wire logic  CMD_VALID_I,
	input wire logic  [95:0] CDB_I,
	input wire logic  NV_READY_I,
	input wire logic  DATA_READY_I,
	input srr_byte_t  DATA_O,
	input wire logic  BUSY_O,
	input wire logic  DONE_O,
	input srr_result_t RESULT_O,
	input srr_sense_t SENSE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);
	wire       take = CMD_VALID_I && !BUSY_O;
	wire [7:0] op   = CDB_I[95:88];
	wire       rel  = take && (op == OP_RELEASE6 || op == OP_RELEASE10);
	wire       rdi  = take && op == OP_MAINT_IN && CDB_I[84:80] == SA_REPORT_ID;
	wire       luns = take && op == OP_REPORT_LUNS;
	sequence s_bad;
		DONE_O && RESULT_O.status == ST_CHECK && RESULT_O.sense.asc == ASC_INVALID_CDB;
	endsequence
	chk_rel_good: assert property (rel && !CDB_I[84] && !CDB_I[80]
		|-> ##2 DONE_O && RESULT_O.status == ST_GOOD) else $error("release not good");
	chk_tp_refused: assert property (rel && CDB_I[84] |-> ##2 s_bad)
		else $error("third party release taken");
	chk_ext_refused: assert property (rel && CDB_I[80] |-> ##2 s_bad)
		else $error("extent release taken");
	chk_lun_short: assert property (luns && CDB_I[47:16] < LUN_MIN_ALLOC |-> ##2 s_bad)
		else $error("short lun allocation taken");
	chk_lun_first: assert property (luns && CDB_I[47:16] >= LUN_MIN_ALLOC
		|-> ##2 DATA_O.valid && DATA_O.data == 8'h00) else $error("lun list start wrong");
	chk_nv_busy: assert property (rdi && !NV_READY_I
		|-> ##2 DONE_O && RESULT_O.sense.key == SK_NOT_READY) else $error("not ready missed");
	chk_lun_field: assert property (rdi && NV_READY_I && CDB_I[63:48] != 16'h0 |-> ##2 s_bad)
		else $error("nonzero lun taken");
	chk_sense_kept: assert property (DONE_O && RESULT_O.status == ST_CHECK
		|=> SENSE_O == $past(RESULT_O.sense)) else $error("sense not latched");
	chk_zero_alloc: assert property (take && op == OP_RECV_DIAG && CDB_I[71:56] == 16'h0
		|-> ##1 (!DATA_O.valid) [*2] ##1 DONE_O && RESULT_O.status == ST_GOOD) else $error("zero alloc");
	chk_byte_hold: assert property (DATA_O.valid && !DATA_READY_I
		|=> DATA_O.valid && $stable(DATA_O.data)) else $error("byte dropped in stall");
endmodule
bind srr_cmd srr_cmd_assertions i_chk (.MCLK_I, .SYS_RST_I, .CMD_VALID_I, .CDB_I, .NV_READY_I,
	.DATA_READY_I, .DATA_O, .BUSY_O, .DONE_O, .RESULT_O, .SENSE_O);

// file: tb/srr_host.sv
// host model: takes data-in bytes, stalls every other cycle on request
`timescale 1ns/1ps
module srr_host import srr_pkg::*; (
	input  wire logic clk_i,
	input  wire logic clr_i,
	input  wire logic stall_i,
	input  srr_byte_t data_i,
	output logic      ready_o
);
	logic [7:0] rx [0:31];
	int         cnt;
	int         last_at;
	initial ready_o = 1'b1;
	always @(negedge clk_i) ready_o <= stall_i ? !ready_o : 1'b1;
	// last_at: index of the first byte that carried the last flag, -1 if none
	always @(posedge clk_i) begin
		if (clr_i) begin
			cnt <= 0;
			last_at <= -1;
		end else if (data_i.valid && ready_o) begin
			rx[cnt] <= data_i.data;
			cnt <= cnt + 1;
			if (data_i.last && last_at < 0) last_at <= cnt;
		end
	end
endmodule

// file: tb/srr_cmd_tb.sv
// bench: directed scenarios for the release/report command handler
`timescale 1ns/1ps
module srr_cmd_tb;
	import srr_pkg::*;
	localparam logic [11:0] BAD = {SK_ILLEGAL_REQ, ASC_INVALID_CDB};
	localparam logic [11:0] NRDY = {SK_NOT_READY, ASC_NOT_READY};
	logic        clk = 0, rst = 1, cmd_v = 0, led = 0, nv = 1, id_we = 0, len_we = 0, stall = 0, rdy;
	logic [95:0] cdb = '0;
	logic [3:0]  id_a = '0;
	logic [7:0]  id_d = '0;
	logic [31:0] id_len = '0;
	srr_byte_t   dout;
	srr_result_t res;
	srr_sense_t  sense;
	logic        busy, done, rel;
	int          num_errors = 0, n_checks = 0, rel_cnt = 0;
	srr_cmd i_srr_cmd (.MCLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(cmd_v), .CDB_I(cdb), .LED_CTRL_I(led),
		.NV_READY_I(nv), .ID_WR_I(id_we), .ID_WADDR_I(id_a), .ID_WDATA_I(id_d), .ID_LEN_WR_I(len_we),
		.ID_LEN_I(id_len), .DATA_READY_I(rdy), .DATA_O(dout), .BUSY_O(busy), .DONE_O(done),
		.RESULT_O(res), .SENSE_O(sense), .RELEASE_O(rel));
	srr_host i_srr_host (.clk_i(clk), .clr_i(cmd_v), .stall_i(stall), .data_i(dout), .ready_o(rdy));
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (rel === 1'b1) rel_cnt++;
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmd(input logic [95:0] c, input logic [7:0] st, input logic [11:0] sk, input int n,
		input logic [127:0] b);
		int t;
		t = 0;
		cmd_v = 1;
		cdb = c;
		@(negedge clk) cmd_v = 0;
		ck(busy, 1);
		while (done !== 1'b1 && t < 200) begin
			@(negedge clk);
			t++;
		end
		ck(done, 1);
		ck(res.status, st);
		if (st == ST_CHECK) ck({res.sense.key, res.sense.asc}, sk);
		ck(i_srr_host.cnt, n);
		ck(i_srr_host.last_at, n - 1);
		ck(busy, 0);
		for (int i = 0; i < n; i++) ck(i_srr_host.rx[i], b[127-8*i -: 8]);
		@(negedge clk);
		if (st == ST_CHECK) ck({sense.key, sense.asc}, sk);
	endtask
	task automatic put_id(input logic [31:0] len, input logic [39:0] v);
		id_len = len;
		len_we = 1;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk) len_we = 0;
			id_we = 1;
			id_a = i[3:0];
			id_d = v[39-8*i -: 8];
		end
		@(negedge clk) id_we = 0;
	endtask
	task automatic t_led;
		led = 1;
		cmd({24'h1c00a0, 16'h10, 56'h0}, ST_GOOD, 0, 6, {48'ha00000020001, 80'h0});
		cmd({24'h1c00a0, 16'h3, 56'h0}, ST_GOOD, 0, 3, {24'ha00000, 104'h0});
		cmd({24'h1c00a0, 16'h0, 56'h0}, ST_GOOD, 0, 0, 0);
		led = 0;
		cmd({24'h1c00a0, 16'h6, 56'h0}, ST_GOOD, 0, 6, {48'ha00000020000, 80'h0});
		$display("test led page done");
	endtask
	task automatic t_rel;
		logic [7:0] ops [2] = '{OP_RELEASE6, OP_RELEASE10};
		logic [7:0] f1 [3] = '{8'h00, 8'h10, 8'h01};
		int r;
		foreach (ops[i]) foreach (f1[j]) begin
			r = rel_cnt;
			cmd({ops[i], f1[j], 16'h5a3c, 64'h0}, j ? ST_CHECK : ST_GOOD, BAD, 0, 0);
			ck(rel_cnt - r, j ? 0 : 1);
		end
		$display("test release done");
	endtask
	task automatic t_id;
		cmd({32'ha3050000, 16'h0, 32'h10, 16'h0}, ST_GOOD, 0, 4, 0);
		put_id(32'h5, 40'h1112131415);
		stall = 1;
		cmd({32'ha3050000, 16'h0, 32'h6, 16'h0}, ST_GOOD, 0, 6, {48'h51112, 80'h0});
		stall = 0;
		cmd({32'ha3050000, 16'h0, 32'h9, 16'h0}, ST_GOOD, 0, 9, {72'h51112131415, 56'h0});
		cmd({32'ha3050000, 16'h1, 32'h9, 16'h0}, ST_CHECK, BAD, 0, 0);
		cmd({32'ha3060000, 16'h0, 32'h9, 16'h0}, ST_CHECK, BAD, 0, 0);
		nv = 0;
		cmd({32'ha3050000, 16'h0, 32'h9, 16'h0}, ST_CHECK, NRDY, 0, 0);
		nv = 1;
		$display("test identifier done");
	endtask
	task automatic t_lun;
		stall = 1;
		cmd({8'ha0, 40'h0, 32'h18, 16'h0}, ST_GOOD, 0, 16, 128'h8 << 96);
		stall = 0;
		cmd({8'ha0, 40'h0, 32'h10, 16'h0}, ST_GOOD, 0, 16, 128'h8 << 96);
		cmd({8'ha0, 40'h0, 32'hf, 16'h0}, ST_CHECK, BAD, 0, 0);
		cmd({8'hff, 88'h0}, ST_CHECK, BAD, 0, 0);
		$display("test lun report done");
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst = 0;
		@(negedge clk);
		t_led;
		t_rel;
		t_id;
		t_lun;
		print_verdict;
	end
	// tests need under 200 cycles; fifty times that is a hang
	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end
endmodule
